/* verilog/t1_line_performance_monitor.sv */
// line performance monitor: classifies seconds, declares frame and signal loss
// assumes a framer on mclk giving frame starts and fs-bit / crc strobes;
// the line pulse input is asynchronous and is synchronised here
//
// What this block does
// R01 - a second with more than one and fewer than 320 crc6 errors is a bursty errored second.
// R02 - a second with any crc6 error or any out-of-frame event is errored.
// R03 - a second with 320 or more crc6 errors or any out-of-frame event is severely errored.
// R04 - out-of-frame is raised when two of the last four framing bits examined are wrong.
// R05 - loss of frame is declared after frame sync stays lost for 2.5 seconds.
// R06 - a counter rises once per loss-of-frame declaration.
// R07 - unavailable service is counted in whole seconds.
// R08 - in extended superframe mode 24 frames form one superframe.
// R09 - in d4 mode 12 frames form one superframe.
// R10 - loss of signal is reported when no pulses are seen on the line.
// R11 - alarm indication signal is sent while a fault exists at or before the transmitter.
// R12 - yellow alarm is sent while the incoming signal is lost.
// R13 - in extended superframe mode the data link bits are flagged as overhead, not payload.
// R14 - the line runs at 1.544 mbps made of 64 kbps channels.
// R15 - a one-second timebase closes each interval's classification and counts.
`timescale 1ns/1ns
module t1_line_performance_monitor #(
  parameter int unsigned SEC_CYCLES = t1_mon_pkg::SECOND_CYCLES,
  parameter int unsigned LOF_CYC    = t1_mon_pkg::LOF_CYCLES,
  parameter int unsigned LOS_CYC    = t1_mon_pkg::LOS_CYCLES
) (
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  clkEn,
  input  wire logic                  esfMode,
  input  wire logic                  linePulse,
  input  wire logic                  frameStart,
  input  wire logic                  fsValid,
  input  wire logic                  fsError,
  input  wire logic                  crcError,
  input  wire logic                  txFault,
  output logic                       oofActive,
  output logic                       lofActive,
  output logic                       losActive,
  output logic                       aisSend,
  output logic                       yellowSend,
  output logic                       superStart,
  output logic                       fdlSlot,
  output logic                       secTick,
  output t1_mon_pkg::sec_class_s     secClass,
  output t1_mon_pkg::perf_cnt_s      perfCnt
);
  import t1_mon_pkg::*;

  // ----------------------------------------
  // line pulse synchroniser and loss of signal
  // ----------------------------------------
  logic pulseMeta_q, pulseSync_q, pulsePrev_q;
  logic [31:0] losCnt_q, losCnt_d;
  logic losActive_q, losActive_d;
  logic pulseEdge;

  // 1.544 mbps line pulses are far slower than mclk, so no edge slips past [R14]
  assign pulseEdge = pulseSync_q & ~pulsePrev_q;

  always_comb begin
    losCnt_d    = losCnt_q;
    losActive_d = losActive_q;
    if (pulseEdge) begin
      losCnt_d    = '0;
      losActive_d = 1'b0;
    end else if (losCnt_q >= 32'(LOS_CYC - 1)) begin
      losActive_d = 1'b1; // [R10]
    end else begin
      losCnt_d = losCnt_q + 32'd1;
    end
  end

  // ----------------------------------------
  // superframe position (R08/R09) and fdl slots
  // ----------------------------------------
  logic [4:0] frameIdx_q, frameIdx_d;
  logic [4:0] lastFrame;

  assign lastFrame = esfMode ? 5'(ESF_FRAMES - 1) : 5'(D4_FRAMES - 1); // [R08] [R09]

  always_comb begin
    frameIdx_d = frameIdx_q;
    if (frameStart) begin
      frameIdx_d = (frameIdx_q >= lastFrame) ? 5'h00 : frameIdx_q + 5'h01;
    end
  end

  assign superStart = frameStart & (frameIdx_q == 5'h00);
  // odd frames carry the data link bit in esf, never user payload
  assign fdlSlot    = esfMode & frameIdx_q[0]; // [R13]

  // ----------------------------------------
  // out-of-frame on 2 of 4 framing bits, loss of frame persistence
  // ----------------------------------------
  logic [3:0] fsHist_q, fsHist_d;
  logic oof_q, oof_d;
  logic [31:0] lofCnt_q, lofCnt_d;
  logic lof_q, lof_d;
  logic lofDeclare;

  function automatic logic [2:0] popCount4(input logic [3:0] v);
    return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  always_comb begin
    fsHist_d   = fsHist_q;
    oof_d      = oof_q;
    lofCnt_d   = lofCnt_q;
    lof_d      = lof_q;
    lofDeclare = 1'b0;
    if (fsValid) begin
      fsHist_d = {fsHist_q[2:0], fsError};
      // resync happens when the window is clean again
      if (popCount4(fsHist_d) >= 3'(OOF_BAD_LIMIT)) begin
        oof_d = 1'b1; // [R04]
      end else if (fsHist_d == 4'h0) begin
        oof_d = 1'b0;
      end
    end
    if (!oof_q) begin
      lofCnt_d = '0;
      lof_d    = 1'b0;
    end else if (!lof_q) begin
      if (lofCnt_q >= 32'(LOF_CYC - 1)) begin
        lof_d      = 1'b1; // [R05]
        lofDeclare = 1'b1;
      end else begin
        lofCnt_d = lofCnt_q + 32'd1;
      end
    end
  end

  // ----------------------------------------
  // one-second interval accounting
  // ----------------------------------------
  logic [31:0] secCnt_q, secCnt_d;
  logic [8:0]  crcCnt_q, crcCnt_d;
  logic        oofSeen_q, oofSeen_d;
  logic        tick;
  sec_class_s  cls_q, cls_d;
  perf_cnt_s   cnt_q, cnt_d;
  logic [8:0]  crcTotal;

  // saturates at 320: larger counts change no class
  function automatic logic [8:0] satInc(input logic [8:0] v, input logic inc);
    return (inc && v < 9'(SES_CRC_LIMIT)) ? v + 9'h001 : v;
  endfunction

  assign tick     = (secCnt_q >= 32'(SEC_CYCLES - 1)); // [R15]
  assign crcTotal = satInc(crcCnt_q, crcError);

  always_comb begin
    secCnt_d  = tick ? '0 : secCnt_q + 32'd1;
    crcCnt_d  = crcTotal;
    oofSeen_d = oofSeen_q | oof_d;
    cls_d     = cls_q;
    cnt_d     = cnt_q;
    if (lofDeclare) begin
      cnt_d.lofCount = cnt_q.lofCount + 16'h0001; // [R06]
    end
    if (tick) begin
      // an event in the closing cycle still counts in this second
      cls_d.esSec  = (crcTotal != 9'h000) | oofSeen_d; // [R02]
      cls_d.besSec = (crcTotal > 9'h001) & (crcTotal < 9'(SES_CRC_LIMIT)); // [R01]
      cls_d.sesSec = (crcTotal >= 9'(SES_CRC_LIMIT)) | oofSeen_d; // [R03]
      cls_d.uasSec = lof_d | losActive_d; // [R07]
      if (cls_d.esSec)  cnt_d.esCount  = cnt_q.esCount + 16'h0001;
      if (cls_d.besSec) cnt_d.besCount = cnt_q.besCount + 16'h0001;
      if (cls_d.sesSec) cnt_d.sesCount = cnt_q.sesCount + 16'h0001;
      if (cls_d.uasSec) cnt_d.uasCount = cnt_q.uasCount + 16'h0001; // [R07]
      crcCnt_d  = 9'h000;
      oofSeen_d = oof_d;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pulseMeta_q <= 1'b0;
      pulseSync_q <= 1'b0;
      pulsePrev_q <= 1'b0;
      losCnt_q    <= '0;
      losActive_q <= 1'b0;
      frameIdx_q  <= 5'h00;
      fsHist_q    <= 4'h0;
      oof_q       <= 1'b0;
      lofCnt_q    <= '0;
      lof_q       <= 1'b0;
      secCnt_q    <= '0;
      crcCnt_q    <= 9'h000;
      oofSeen_q   <= 1'b0;
      cls_q       <= '0;
      cnt_q       <= {5{CNT_RESET}};
      secTick     <= 1'b0;
    end else if (clkEn) begin
      pulseMeta_q <= linePulse;
      pulseSync_q <= pulseMeta_q;
      pulsePrev_q <= pulseSync_q;
      losCnt_q    <= losCnt_d;
      losActive_q <= losActive_d;
      frameIdx_q  <= frameIdx_d;
      fsHist_q    <= fsHist_d;
      oof_q       <= oof_d;
      lofCnt_q    <= lofCnt_d;
      lof_q       <= lof_d;
      secCnt_q    <= secCnt_d;
      crcCnt_q    <= crcCnt_d;
      oofSeen_q   <= oofSeen_d;
      cls_q       <= cls_d;
      cnt_q       <= cnt_d;
      secTick     <= tick;
    end
  end

  // ----------------------------------------
  // outputs and outbound alarms
  // ----------------------------------------
  assign oofActive  = oof_q;
  assign lofActive  = lof_q;
  assign losActive  = losActive_q;
  assign aisSend    = txFault; // [R11]
  assign yellowSend = lof_q | losActive_q; // [R12]
  assign secClass   = cls_q;
  assign perfCnt    = cnt_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_bes_range: assert property (@(posedge mclk) disable iff (!resetn) // [R01]
    clkEn && tick && crcTotal == 9'h001 |=> !secClass.besSec)
    else $error("single crc error marked bursty");
  a_es_oof: assert property (@(posedge mclk) disable iff (!resetn) // [R02]
    clkEn && tick && oofSeen_d |=> secClass.esSec)
    else $error("oof second not errored");
  a_ses_limit: assert property (@(posedge mclk) disable iff (!resetn) // [R03]
    clkEn && tick && crcTotal >= 9'(SES_CRC_LIMIT) |=> secClass.sesSec && !secClass.besSec)
    else $error("320 crc errors not severe");
  a_oof_two: assert property (@(posedge mclk) disable iff (!resetn) // [R04]
    clkEn && fsValid && fsError && fsHist_q[0] |=> oofActive)
    else $error("two bad framing bits gave no oof");
  a_lof_early: assert property (@(posedge mclk) disable iff (!resetn) // [R05]
    $rose(lofActive) |-> $past(oofActive, 2))
    else $error("lof without preceding oof");
  a_lof_count: assert property (@(posedge mclk) disable iff (!resetn) // [R06]
    $rose(lofActive) |-> perfCnt.lofCount == $past(perfCnt.lofCount) + 16'h0001)
    else $error("lof counter missed declaration");
  a_uas_count: assert property (@(posedge mclk) disable iff (!resetn) // [R07]
    clkEn && tick && lof_q && oof_q |=> perfCnt.uasCount == $past(perfCnt.uasCount) + 16'h0001)
    else $error("unavailable second not counted");
  a_los_clear: assert property (@(posedge mclk) disable iff (!resetn) // [R10]
    clkEn && pulseEdge |=> !losActive)
    else $error("line pulse left signal loss standing");
  a_yellow_los: assert property (@(posedge mclk) disable iff (!resetn) // [R12]
    losActive |-> yellowSend)
    else $error("no yellow with signal lost");
  a_frame_wrap: assert property (@(posedge mclk) disable iff (!resetn) // [R09]
    clkEn && frameStart && !esfMode |=> frameIdx_q < 5'(D4_FRAMES))
    else $error("d4 frame index past 11");

  c_oof:  cover property (@(posedge mclk) disable iff (!resetn) $rose(oofActive));
  c_lof:  cover property (@(posedge mclk) disable iff (!resetn) $rose(lofActive));
  c_bes:  cover property (@(posedge mclk) disable iff (!resetn) $rose(secClass.besSec));
  c_los:  cover property (@(posedge mclk) disable iff (!resetn) $rose(losActive));

endmodule

/* verilog/t1_mon_pkg.sv */
// package for the line performance monitor: timing constants and carriers
// assumes a 125 MHz mclk and a framer that supplies per-frame event strobes
package t1_mon_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned SECOND_NS      = 1000000000;
  localparam int unsigned SECOND_CYCLES  = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned LOF_PERSIST_MS = 2500;
  localparam int unsigned LOF_CYCLES     = (LOF_PERSIST_MS / 1000) * SECOND_CYCLES
                                           + (LOF_PERSIST_MS % 1000) * (1000000 / CLK_PERIOD_NS);
  localparam int unsigned LOS_CYCLES     = 1024;

  // ----------------------------------------
  // thresholds, frame counts, widths
  // ----------------------------------------
  localparam int unsigned SES_CRC_LIMIT  = 320;
  localparam int unsigned OOF_WINDOW     = 4;
  localparam int unsigned OOF_BAD_LIMIT  = 2;
  localparam int unsigned ESF_FRAMES     = 24;
  localparam int unsigned D4_FRAMES      = 12;
  localparam int unsigned LINE_KBPS      = 1544;
  localparam int unsigned DS0_KBPS       = 64;
  localparam int unsigned CNT_W          = 16;

  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

  typedef struct packed {
    logic esSec;
    logic besSec;
    logic sesSec;
    logic uasSec;
  } sec_class_s;

  typedef struct packed {
    logic [CNT_W-1:0] lofCount;
    logic [CNT_W-1:0] uasCount;
    logic [CNT_W-1:0] esCount;
    logic [CNT_W-1:0] besCount;
    logic [CNT_W-1:0] sesCount;
  } perf_cnt_s;

endpackage

/* tb/t1_line_model.sv */
// line model: line pulses, frame strobes, framing bits and crc events
// assumes controls change just after the mclk rising edge
`timescale 1ns/1ns
module t1_line_model (
  input  wire logic       mclk,
  input  wire logic       lineOn,
  input  wire logic       fsBad,
  input  wire logic       crcGo,
  input  wire logic [9:0] crcN,
  output logic            linePulse  = 1'b0,
  output logic            frameStart = 1'b0,
  output logic            fsValid    = 1'b0,
  output logic            fsError    = 1'b0,
  output logic            crcError   = 1'b0
);
  // ----------------------------------------
  // frames of eight cycles, one framing bit each
  // ----------------------------------------
  logic [2:0] phase = 3'h0;
  logic [9:0] left  = 10'h000;
  always @(posedge mclk) begin
    phase      <= phase + 3'h1;
    linePulse  <= lineOn & ~linePulse;
    frameStart <= (phase == 3'h7);
    fsValid    <= (phase == 3'h7);
    // between framing bits fsError wanders, so it must be ignored
    fsError    <= (phase == 3'h7) ? fsBad : ~fsError;
    crcError   <= (left != 10'h000) & ~crcGo;
    if (crcGo) begin
      left <= crcN;
    end else if (left != 10'h000) begin
      left <= left - 10'h001;
    end
  end
endmodule

/* tb/tb_t1_line_performance_monitor.sv */
// bench for the line performance monitor, with a line model on the far side
// assumes short simulation counts set through the monitor's parameters
`timescale 1ns/1ns
module tb_t1_line_performance_monitor;
  import t1_mon_pkg::*;
  localparam int unsigned SEC = 400;
  localparam int unsigned LOFC = 50;
  `define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
  `define WAITV(s, v, lim) begin n = 0; while ((s) !== (v) && n < (lim)) begin @(negedge mclk); n++; end end
  typedef struct { int n; logic es; logic bes; logic ses; } row_s;
  row_s rows [5] = '{'{0, 0, 0, 0}, '{1, 1, 0, 0}, '{2, 1, 1, 0}, '{319, 1, 1, 0}, '{320, 1, 0, 1}};
  logic mclk = 1'b0, resetn = 1'b0, esfMode = 1'b1, txFault = 1'b0;
  logic clkEn = 1'b1, s0;
  logic lineOn = 1'b1, fsBad = 1'b0, crcGo = 1'b0;
  logic [9:0] crcN = 10'h000;
  logic linePulse, frameStart, fsValid, fsError, crcError;
  logic oofActive, lofActive, losActive, aisSend, yellowSend, superStart, fdlSlot, secTick;
  sec_class_s secClass;
  perf_cnt_s perfCnt, pc;
  logic [CNT_W-1:0] ees = 16'h0000, ebes = 16'h0000, eses = 16'h0000;
  int fail_count = 0, checked = 0, n;
  always #4 mclk = ~mclk;
  t1_line_model line_u (.mclk(mclk), .lineOn(lineOn), .fsBad(fsBad), .crcGo(crcGo), .crcN(crcN),
    .linePulse(linePulse), .frameStart(frameStart), .fsValid(fsValid), .fsError(fsError), .crcError(crcError));
  t1_line_performance_monitor #(.SEC_CYCLES(SEC), .LOF_CYC(LOFC), .LOS_CYC(16)) dut_u (.mclk(mclk),
    .resetn(resetn), .clkEn(clkEn), .esfMode(esfMode), .linePulse(linePulse), .frameStart(frameStart),
    .fsValid(fsValid), .fsError(fsError), .crcError(crcError), .txFault(txFault), .oofActive(oofActive),
    .lofActive(lofActive), .losActive(losActive), .aisSend(aisSend), .yellowSend(yellowSend),
    .superStart(superStart), .fdlSlot(fdlSlot), .secTick(secTick), .secClass(secClass), .perfCnt(perfCnt));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic waitSec;
    @(negedge mclk);
    `WAITV(secTick, 1'b1, SEC + 10)
    if (n >= SEC + 10) fail_count++;
  endtask
  // frames between superframe starts, and the data link slot on the second frame
  task automatic superCheck(input logic m, input int frames);
    int f;
    f = 0;
    @(posedge mclk) esfMode <= m;
    repeat (2) begin
      @(negedge mclk);
      `WAITV(superStart, 1'b1, 400)
    end
    do begin
      @(negedge mclk);
      if (frameStart === 1'b1) f++;
      if (f == 1 && frameStart === 1'b1) `CHK("fdlSlot", m, fdlSlot)
    end while (superStart !== 1'b1 && f < 40);
    `CHK("superLen", frames, f)
    $display("superframe mode %0d done", m);
  endtask
  initial begin
    #(8 * 60000);
    fail_count++;
    results;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    `CHK("lofCount", 16'h0000, perfCnt.lofCount)
    foreach (rows[k]) begin
      waitSec;
      @(posedge mclk);
      crcN  <= rows[k].n[9:0];
      crcGo <= 1'b1;
      @(posedge mclk) crcGo <= 1'b0;
      waitSec;
      ees  = ees + CNT_W'(rows[k].es);
      ebes = ebes + CNT_W'(rows[k].bes);
      eses = eses + CNT_W'(rows[k].ses);
      `CHK("esSec", rows[k].es, secClass.esSec)
      `CHK("besSec", rows[k].bes, secClass.besSec)
      `CHK("sesSec", rows[k].ses, secClass.sesSec)
      `CHK("esCount", ees, perfCnt.esCount)
      `CHK("besCount", ebes, perfCnt.besCount)
      `CHK("sesCount", eses, perfCnt.sesCount)
      $display("row %0d done", k);
    end
    // bad framing bits: out of frame, then loss of frame after the persistence span
    @(posedge mclk) fsBad <= 1'b1;
    `WAITV(oofActive, 1'b1, 40)
    `CHK("oofActive", 1'b1, oofActive)
    `WAITV(lofActive, 1'b1, 200)
    `CHK("lofDelay", LOFC, n)
    `CHK("lofCount", 16'h0001, perfCnt.lofCount)
    `CHK("yellowSend", 1'b1, yellowSend)
    waitSec;
    waitSec;
    `CHK("uasSec", 1'b1, secClass.uasSec)
    `CHK("sesSec", 1'b1, secClass.sesSec)
    `CHK("uasCount", 16'h0002, perfCnt.uasCount)
    @(posedge mclk) fsBad <= 1'b0;
    `WAITV(oofActive, 1'b0, 60)
    @(negedge mclk);
    `CHK("lofActive", 1'b0, lofActive)
    `CHK("lofCount", 16'h0001, perfCnt.lofCount)
    $display("frame loss done");
    // line goes silent, then comes back
    @(posedge mclk) lineOn <= 1'b0;
    `WAITV(losActive, 1'b1, 60)
    `CHK("losActive", 1'b1, losActive)
    `CHK("yellowSend", 1'b1, yellowSend)
    @(posedge mclk) lineOn <= 1'b1;
    `WAITV(losActive, 1'b0, 20)
    `CHK("yellowSend", 1'b0, yellowSend)
    @(posedge mclk) txFault <= 1'b1;
    @(negedge mclk) `CHK("aisSend", 1'b1, aisSend)
    @(posedge mclk) txFault <= 1'b0;
    @(negedge mclk) `CHK("aisSend", 1'b0, aisSend)
    $display("alarms done");
    superCheck(1'b1, ESF_FRAMES);
    superCheck(1'b0, D4_FRAMES);
    // clock enable low freezes every monitor register, even with bad framing bits arriving
    @(posedge mclk) begin
      clkEn <= 1'b0;
      fsBad <= 1'b1;
    end
    @(negedge mclk);
    s0 = secTick;
    pc = perfCnt;
    `WAITV(secTick, ~s0, SEC + 100)
    `CHK("frozenTick", SEC + 100, n)
    `CHK("frozenOof", 1'b0, oofActive)
    `CHK("frozenCnt", pc, perfCnt)
    @(posedge mclk) begin
      clkEn <= 1'b1;
      fsBad <= 1'b0;
    end
    $display("clock enable done");
    // second reset in mid-run must clear every count
    @(posedge mclk) resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk) `CHK("perfCnt", '0, perfCnt)
    // first edges after release bring back no stale class or alarm
    repeat (2) @(negedge mclk);
    `CHK("perfCnt", '0, perfCnt)
    `CHK("secClass", '0, secClass)
    `CHK("lofActive", 1'b0, lofActive)
    $display("reset done");
    results;
  end
endmodule
